// *** common/backlight_pkg.sv ***
/*
 * Shared constants and carrier types of the backlight control register bank.
 * Assumes a single system clock; every module imports the whole package.
 */
package backlight_pkg;

	// ------------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------------
	localparam logic [7:0] ADDR_BRIGHTNESS = 8'h00;
	localparam logic [7:0] ADDR_DEVICE_CTRL = 8'h01;
	localparam logic [7:0] ADDR_FAULT = 8'h02;
	localparam logic [7:0] ADDR_IDENT = 8'h03;
	localparam logic [7:0] ADDR_DIRECT = 8'h04;
	localparam logic [7:0] ADDR_TEMP_HIGH = 8'h05;
	localparam logic [7:0] ADDR_TEMP_LOW = 8'h06;
	localparam logic [7:0] ADDR_NVM = 8'h72;

	// ------------------------------------------------------------------
	// Reset values and field positions
	// ------------------------------------------------------------------
	localparam logic [7:0] RESET_BRIGHTNESS = 8'h00;
	localparam logic [2:0] RESET_DEVICE_CTRL = 3'h0;
	localparam logic [7:0] RESET_FAULT = 8'h00;
	localparam logic [5:0] RESET_DIRECT = 6'h00;
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_MODE_LSB = 1;
	localparam int NVM_READY_BIT = 7;

	// ------------------------------------------------------------------
	// Brightness source codes and serial target address
	// ------------------------------------------------------------------
	localparam logic [1:0] SRC_PIN_DUTY_A = 2'h0;
	localparam logic [1:0] SRC_PIN_DUTY_B = 2'h1;
	localparam logic [1:0] SRC_REGISTER = 2'h2;
	localparam logic [1:0] SRC_PIN_DIRECT = 2'h3;
	localparam logic [6:0] TARGET_ADDRESS = 7'h2C;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	// Default clock divide for PWM generation and duty measurement
	localparam int PWM_TICK_DIV = 4;

	// ------------------------------------------------------------------
	// Carrier types
	// ------------------------------------------------------------------
	typedef struct packed {
		logic led_open_flag;
		logic led_short_flag;
		logic multi_channel_fault_flag;
		logic single_channel_fault_flag;
		logic any_led_fault_flag;
		logic overcurrent_flag;
		logic thermal_shutdown_flag;
		logic low_input_voltage_flag;
	} fault_bits_t;

	typedef struct packed {
		logic nvm_init_cmd;
		logic nvm_program_cmd;
		logic nvm_load_cmd;
	} nvm_cmd_t;

	typedef struct packed {
		logic valid;
		logic [7:0] addr;
		logic [7:0] data;
	} reg_access_t;

	// Register source selection: pin duty measurement
	function automatic logic source_is_pin_duty(input logic [1:0] mode);
		return (mode == SRC_PIN_DUTY_A) || (mode == SRC_PIN_DUTY_B);
	endfunction

	// Register source selection: register control
	function automatic logic source_is_register(input logic [1:0] mode);
		return mode == SRC_REGISTER;
	endfunction

endpackage

// *** design/backlight_control_registers.sv ***
/*
 * Control and status register bank of the LED backlight driver with its
 * serial target port, brightness source selection and PWM generation.
 * Assumes scl, sda and pwm pins are synchronous to clk; sda is open drain,
 * resolved outside from sda_oe_n.
 */
// Behaviour
// (RULE1) Brightness register at zero sets duty
// (RULE2) Modes 00/01 take brightness from pin duty
// (RULE3) Mode 10 takes brightness from register
// (RULE4) Mode 11 passes pin straight to LEDs
// (RULE5) Register mode, enable clear turns chip off
// (RULE6) Register mode, enable set turns chip on
// (RULE7) Pin modes follow pin, ignore enable
// (RULE8) Open fault sets bit 7, drives fault low
// (RULE9) Brightness, control, fault reset to zero
// (RULE10) Faults clear on read or enable low
// (RULE11) Answer only serial address 2Ch
// (RULE12) Register address increments after each data byte; code holds it after an unacknowledged read byte
// (RULE13) Unassigned bits read zero, writes ignored
`timescale 1ns/100ps
module backlight_control_registers
	import backlight_pkg::*;
#(
	parameter int TICK_DIV = PWM_TICK_DIV,
	parameter logic [7:0] IDENT_VALUE = 8'hA5 // Arbitrary identification value
)
(
	input wire logic clk,
	input wire logic srst,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	input wire logic pwm_in,
	input wire logic en_pin,
	input wire fault_bits_t fault_events,
	input wire logic [10:0] temp_value,
	input wire logic nvm_ready,
	output nvm_cmd_t nvm_cmd,
	output logic led_pwm,
	output logic chip_on,
	output logic backlight_on,
	output logic [7:0] brightness_level_out,
	output logic [5:0] direct_outputs,
	output logic fault_n
);

	typedef enum {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_REG,
		ST_REG_ACK,
		ST_WDATA,
		ST_WDATA_ACK,
		ST_RDATA,
		ST_RDATA_ACK
	} serial_state_t;

	serial_state_t state_reg;
	logic [7:0] shift_reg;
	logic [7:0] tx_reg;
	logic [3:0] bit_count_reg;
	logic [7:0] pointer_reg;
	logic read_dir_reg;
	logic master_ack_reg;
	logic drive_low_reg;
	logic [7:0] fetch_now;
	logic [7:0] fetch_after;
	reg_access_t write_req;
	reg_access_t read_req;

	logic [7:0] brightness_value;
	logic [1:0] brightness_source_select;
	logic backlight_enable_bit;
	fault_bits_t fault_reg;
	fault_bits_t fault_next;
	logic [5:0] direct_reg;
	nvm_cmd_t nvm_cmd_next;

	logic sda_level;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;

	logic [$clog2(TICK_DIV + 1) - 1:0] div_reg;
	logic tick;
	logic [7:0] pwm_count_reg;
	logic [7:0] measured_duty;
	logic pin_active;
	logic [7:0] level_sel;
	logic chip_on_next;

	// ------------------------------------------------------------------
	// Line sampling and pin duty measurement
	// ------------------------------------------------------------------
	serial_line_sampler u_sampler (
		.clk(clk),
		.srst(srst),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.sda_level(sda_level),
		.scl_rise(scl_rise),
		.scl_fall(scl_fall),
		.start_seen(start_seen),
		.stop_seen(stop_seen)
	);

	pwm_duty_meter u_meter (
		.clk(clk),
		.srst(srst),
		.sample_tick(tick),
		.pwm_pin(pwm_in),
		.duty_level(measured_duty),
		.pin_active(pin_active)
	);

	// ------------------------------------------------------------------
	// Register read decode
	// ------------------------------------------------------------------
	// Unmapped addresses read as zero
	function automatic logic [7:0] read_value(input logic [7:0] addr);
		unique case (addr)
			ADDR_BRIGHTNESS: read_value = brightness_value;
			ADDR_DEVICE_CTRL: read_value = {5'h00, brightness_source_select,
				backlight_enable_bit}; // RULE13
			ADDR_FAULT: read_value = fault_reg;
			ADDR_IDENT: read_value = IDENT_VALUE;
			ADDR_DIRECT: read_value = {1'b0, direct_reg, 1'b0}; // RULE13
			ADDR_TEMP_HIGH: read_value = temp_value[10:3];
			ADDR_TEMP_LOW: read_value = {temp_value[2:0], 5'h00}; // RULE13
			ADDR_NVM: read_value = {nvm_ready, 7'h00}; // RULE13
			default: read_value = 8'h00; // RULE13
		endcase
	endfunction

	// Bytes a read may load at the next falling clock edge
	always_comb
	begin
		fetch_now = read_value(pointer_reg);
		fetch_after = read_value(pointer_reg + 8'h01);
	end

	// ------------------------------------------------------------------
	// Serial target state machine
	// ------------------------------------------------------------------
	// Start restarts from any state, so a repeated start needs no special path
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			state_reg <= ST_IDLE;
			shift_reg <= 8'h00;
			tx_reg <= 8'h00;
			bit_count_reg <= 4'h0;
			pointer_reg <= 8'h00;
			read_dir_reg <= 1'b0;
			master_ack_reg <= 1'b0;
			drive_low_reg <= 1'b0;
			write_req <= '0;
			read_req <= '0;
		end
		else
		begin
			write_req.valid <= 1'b0;
			read_req.valid <= 1'b0;
			if (start_seen)
			begin
				state_reg <= ST_ADDR;
				bit_count_reg <= 4'h0;
				drive_low_reg <= 1'b0;
			end
			else if (stop_seen)
			begin
				state_reg <= ST_IDLE;
				drive_low_reg <= 1'b0;
			end
			else if (scl_rise)
			begin
				unique case (state_reg)
					ST_ADDR, ST_REG, ST_WDATA:
					begin
						shift_reg <= {shift_reg[6:0], sda_level};
						bit_count_reg <= bit_count_reg + 4'h1;
					end
					ST_RDATA: bit_count_reg <= bit_count_reg + 4'h1;
					ST_RDATA_ACK: master_ack_reg <= ~sda_level;
					default: ;
				endcase
			end
			else if (scl_fall)
			begin
				unique case (state_reg)
					ST_ADDR:
					begin
						if (bit_count_reg == BITS_PER_BYTE)
						begin
							if (shift_reg[7:1] == TARGET_ADDRESS) // RULE11
							begin
								state_reg <= ST_ADDR_ACK;
								read_dir_reg <= shift_reg[0];
								drive_low_reg <= 1'b1;
							end
							else
							begin
								state_reg <= ST_IDLE; // RULE11
							end
						end
					end
					ST_ADDR_ACK:
					begin
						bit_count_reg <= 4'h0;
						if (read_dir_reg)
						begin
							// First read byte comes from the current pointer
							state_reg <= ST_RDATA;
							drive_low_reg <= ~fetch_now[7];
							tx_reg <= {fetch_now[6:0], 1'b0};
							read_req <= '{valid: 1'b1, addr: pointer_reg, data: 8'h00};
						end
						else
						begin
							state_reg <= ST_REG;
							drive_low_reg <= 1'b0;
						end
					end
					ST_REG:
					begin
						if (bit_count_reg == BITS_PER_BYTE)
						begin
							pointer_reg <= shift_reg;
							state_reg <= ST_REG_ACK;
							drive_low_reg <= 1'b1;
						end
					end
					ST_WDATA:
					begin
						if (bit_count_reg == BITS_PER_BYTE)
						begin
							write_req <= '{valid: 1'b1, addr: pointer_reg, data: shift_reg};
							state_reg <= ST_WDATA_ACK;
							drive_low_reg <= 1'b1;
						end
					end
					ST_REG_ACK, ST_WDATA_ACK:
					begin
						if (state_reg == ST_WDATA_ACK)
						begin
							pointer_reg <= pointer_reg + 8'h01; // RULE12
						end
						state_reg <= ST_WDATA;
						bit_count_reg <= 4'h0;
						drive_low_reg <= 1'b0;
					end
					ST_RDATA:
					begin
						if (bit_count_reg == BITS_PER_BYTE)
						begin
							state_reg <= ST_RDATA_ACK;
							drive_low_reg <= 1'b0;
						end
						else
						begin
							drive_low_reg <= ~tx_reg[7];
							tx_reg <= {tx_reg[6:0], 1'b0};
						end
					end
					ST_RDATA_ACK:
					begin
						bit_count_reg <= 4'h0;
						if (master_ack_reg)
						begin
							// Acknowledged: advance and send the next register
							pointer_reg <= pointer_reg + 8'h01; // RULE12
							state_reg <= ST_RDATA;
							drive_low_reg <= ~fetch_after[7];
							tx_reg <= {fetch_after[6:0], 1'b0};
							read_req <= '{valid: 1'b1, addr: pointer_reg + 8'h01,
								data: 8'h00};
						end
						else
						begin
							state_reg <= ST_IDLE;
						end
					end
					default: ;
				endcase
			end
		end
	end

	// Open drain: only ever pull low
	assign sda_out = 1'b0;
	assign sda_oe_n = ~drive_low_reg;

	// ------------------------------------------------------------------
	// Writable registers
	// ------------------------------------------------------------------
	// Only assigned bits are stored; the rest of a written byte is dropped
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			brightness_value <= RESET_BRIGHTNESS; // RULE9
			{brightness_source_select, backlight_enable_bit} <= RESET_DEVICE_CTRL; // RULE9
			direct_reg <= RESET_DIRECT;
		end
		else if (write_req.valid)
		begin
			if (write_req.addr == ADDR_BRIGHTNESS)
			begin
				brightness_value <= write_req.data; // RULE1
			end
			if (write_req.addr == ADDR_DEVICE_CTRL)
			begin
				brightness_source_select <= write_req.data[CTRL_MODE_LSB +: 2];
				backlight_enable_bit <= write_req.data[CTRL_ENABLE_BIT];
			end
			if (write_req.addr == ADDR_DIRECT)
			begin
				direct_reg <= write_req.data[6:1]; // RULE13
			end
		end
	end

	// Memory commands are one-cycle pulses and read back as zero
	always_comb
	begin
		nvm_cmd_next = '0;
		if (write_req.valid && (write_req.addr == ADDR_NVM))
		begin
			nvm_cmd_next = write_req.data[2:0];
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			nvm_cmd <= '0;
		end
		else
		begin
			nvm_cmd <= nvm_cmd_next;
		end
	end

	// ------------------------------------------------------------------
	// Fault latches
	// ------------------------------------------------------------------
	// A new event wins over a clear in the same cycle so none is lost
	always_comb
	begin
		fault_next = fault_reg;
		if ((read_req.valid && (read_req.addr == ADDR_FAULT)) || !en_pin)
		begin
			fault_next = '0; // RULE10
		end
		fault_next = fault_next | fault_events; // RULE8
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			fault_reg <= RESET_FAULT; // RULE9
		end
		else
		begin
			fault_reg <= fault_next;
		end
	end

	// ------------------------------------------------------------------
	// PWM tick divider and generator
	// ------------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			div_reg <= '0;
		end
		else if (div_reg == ($bits(div_reg))'(TICK_DIV - 1))
		begin
			div_reg <= '0;
		end
		else
		begin
			div_reg <= div_reg + ($bits(div_reg))'(1);
		end
	end

	assign tick = (div_reg == ($bits(div_reg))'(TICK_DIV - 1));

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			pwm_count_reg <= 8'h00;
		end
		else if (tick)
		begin
			pwm_count_reg <= pwm_count_reg + 8'h01;
		end
	end

	// ------------------------------------------------------------------
	// Brightness source and power state
	// ------------------------------------------------------------------
	always_comb
	begin
		if (source_is_register(brightness_source_select))
		begin
			level_sel = brightness_value; // RULE3
			chip_on_next = backlight_enable_bit; // RULE5 RULE6
		end
		else
		begin
			// Pin duty or direct mode: enable bit has no say
			level_sel = source_is_pin_duty(brightness_source_select) ?
				measured_duty : 8'h00; // RULE2
			chip_on_next = pin_active | pwm_in; // RULE7
		end
	end

	// Direct mode adds one clock of delay on the pin, a trade for clean outputs
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			led_pwm <= 1'b0;
			chip_on <= 1'b0;
			backlight_on <= 1'b0;
			brightness_level_out <= 8'h00;
			direct_outputs <= 6'h00;
			fault_n <= 1'b1;
		end
		else
		begin
			chip_on <= chip_on_next;
			backlight_on <= chip_on_next;
			brightness_level_out <= level_sel;
			direct_outputs <= direct_reg;
			fault_n <= ~(|fault_reg); // RULE8
			if (!chip_on_next)
			begin
				led_pwm <= 1'b0;
			end
			else if (brightness_source_select == SRC_PIN_DIRECT)
			begin
				led_pwm <= pwm_in; // RULE4
			end
			else
			begin
				led_pwm <= (pwm_count_reg < level_sel); // RULE1
			end
		end
	end

endmodule

// *** design/pwm_duty_meter.sv ***
/*
 * Measures the duty cycle of the PWM input pin over a window of 256 ticks
 * and reports whether the pin shows any activity.
 * Assumes the pin is synchronous to clk and sample_tick is a one-cycle enable.
 */
`timescale 1ns/100ps
module pwm_duty_meter
	import backlight_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic sample_tick,
	input wire logic pwm_pin,
	output logic [7:0] duty_level,
	output logic pin_active
);

	logic [7:0] window_reg;
	logic [8:0] high_count_reg;
	logic seen_high_reg;

	// ------------------------------------------------------------------
	// Window accumulation
	// ------------------------------------------------------------------
	// Result updates once per window; a full-high window saturates at 255
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			window_reg <= 8'h00;
			high_count_reg <= 9'h000;
			seen_high_reg <= 1'b0;
			duty_level <= 8'h00;
			pin_active <= 1'b0;
		end
		else if (sample_tick)
		begin
			window_reg <= window_reg + 8'h01;
			if (window_reg == 8'hFF)
			begin
				duty_level <= high_count_reg[8] ? 8'hFF : high_count_reg[7:0];
				pin_active <= seen_high_reg | pwm_pin;
				high_count_reg <= {8'h00, pwm_pin};
				seen_high_reg <= pwm_pin;
			end
			else
			begin
				high_count_reg <= high_count_reg + {8'h00, pwm_pin};
				seen_high_reg <= seen_high_reg | pwm_pin;
			end
		end
	end

endmodule

// *** design/serial_line_sampler.sv ***
/*
 * Samples the serial clock and data lines and reports clock edges,
 * start and stop conditions as one-cycle pulses.
 * Assumes both lines are already synchronous to clk.
 */
`timescale 1ns/100ps
module serial_line_sampler
	import backlight_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_level,
	output logic scl_rise,
	output logic scl_fall,
	output logic start_seen,
	output logic stop_seen
);

	logic scl_reg;
	logic sda_reg;

	// ------------------------------------------------------------------
	// Line history
	// ------------------------------------------------------------------
	// Idle bus is high on both lines
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			scl_reg <= 1'b1;
			sda_reg <= 1'b1;
		end
		else
		begin
			scl_reg <= scl_in;
			sda_reg <= sda_in;
		end
	end

	// Data moving while clock is high marks start or stop
	assign sda_level = sda_reg;
	assign scl_rise = scl_in & ~scl_reg;
	assign scl_fall = ~scl_in & scl_reg;
	assign start_seen = scl_in & scl_reg & sda_reg & ~sda_in;
	assign stop_seen = scl_in & scl_reg & ~sda_reg & sda_in;

endmodule

// *** tb/backlight_monitor.sv ***
/*
 * Port checker of the backlight register bank.
 * Assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/100ps
module backlight_monitor
	import backlight_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic scl_in,
	input wire logic sda_oe_n,
	input wire logic en_pin,
	input wire fault_bits_t fault_events,
	input wire logic led_pwm,
	input wire logic chip_on,
	input wire logic backlight_on,
	input wire logic [7:0] brightness_level_out,
	input wire logic fault_n
);
	logic [5:0] scl_hist;
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	// Recent clock line samples, so answers can be tied to a falling edge
	always_ff @(posedge clk)
		scl_hist <= {scl_hist[4:0], scl_in};
	property p_reset_vals;
		$fell(srst) |-> fault_n && sda_oe_n && !chip_on && !led_pwm
			&& brightness_level_out == 8'h00;
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");
	property p_fault_low;
		fault_events != 8'h00 |-> ##2 !fault_n;
	endproperty
	a_fault_low: assert property (p_fault_low) else $error("fault pin not low");
	property p_en_clear;
		(!en_pin && fault_events == 8'h00) [*2] |=> fault_n;
	endproperty
	a_en_clear: assert property (p_en_clear) else $error("enable low kept fault");
	// A release of the fault pin needs a read fetch or the enable pin low
	property p_clear_cause;
		$rose(fault_n) |-> $past(srst) || !$past(en_pin, 2)
			|| (scl_hist[5:1] & ~scl_hist[4:0]) != 5'h00;
	endproperty
	a_clear_cause: assert property (p_clear_cause) else $error("fault cleared alone");
	property p_on_pair;
		chip_on == backlight_on;
	endproperty
	a_on_pair: assert property (p_on_pair) else $error("on flags differ");
	property p_pwm_needs_on;
		$rose(led_pwm) |-> ##[0:2] chip_on;
	endproperty
	a_pwm_needs_on: assert property (p_pwm_needs_on) else $error("pwm while off");
	property p_oe_after_fall;
		$changed(sda_oe_n) |-> $past(srst) || (scl_hist[3:1] & ~scl_hist[2:0]) != 3'h0;
	endproperty
	a_oe_after_fall: assert property (p_oe_after_fall) else $error("data moved late");
	// Data must hold while the clock line is high
	property p_oe_still;
		!$past(srst) && scl_in && scl_hist[1:0] == 2'b11 |-> $stable(sda_oe_n);
	endproperty
	a_oe_still: assert property (p_oe_still) else $error("data moved in high");
endmodule

bind backlight_control_registers backlight_monitor mon (
	.clk(clk), .srst(srst), .scl_in(scl_in), .sda_oe_n(sda_oe_n), .en_pin(en_pin),
	.fault_events(fault_events), .led_pwm(led_pwm), .chip_on(chip_on),
	.backlight_on(backlight_on), .brightness_level_out(brightness_level_out),
	.fault_n(fault_n));

// *** tb/serial_host.sv ***
/*
 * Serial bus host model for the register bank's target port.
 * Assumes the bench resolves the open-drain data wire with a pull-up.
 */
`timescale 1ns/100ps
module serial_host
	import backlight_pkg::*;
(
	input wire logic clk,
	input wire logic sda_line,
	output logic scl = 1'b1,
	output logic sda_o = 1'b1
);
	// Data moves in a step of its own, so no false start or stop appears
	task automatic drv(input logic c, input logic d);
		scl <= c;
		sda_o <= d;
		repeat (3) @(posedge clk);
	endtask
	task automatic bit_io(input logic d, output logic q);
		drv(1'b0, sda_o);
		drv(1'b0, d);
		drv(1'b1, d);
		q = sda_line;
		drv(1'b1, d);
	endtask
	task automatic start_c;
		drv(1'b0, 1'b1);
		drv(1'b1, 1'b1);
		drv(1'b1, 1'b0);
	endtask
	task automatic stop_c;
		drv(1'b0, sda_o);
		drv(1'b0, 1'b0);
		drv(1'b1, 1'b0);
		drv(1'b1, 1'b1);
	endtask
	// Byte out MSB first, then the ninth pulse with data at last
	task automatic xfer(input logic [7:0] d, input logic last,
		output logic [7:0] q, output logic ack);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], q[i]);
		bit_io(last, ack);
		ack = !ack;
	endtask
	task automatic probe(input logic [7:0] b, output logic ack);
		logic [7:0] q;
		start_c();
		xfer(b, 1'b1, q, ack);
		stop_c();
	endtask
	task automatic wr(input logic [7:0] a, d0, d1, input int n);
		logic [7:0] q;
		logic k;
		start_c();
		xfer({TARGET_ADDRESS, 1'b0}, 1'b1, q, k);
		xfer(a, 1'b1, q, k);
		xfer(d0, 1'b1, q, k);
		if (n > 1)
			xfer(d1, 1'b1, q, k);
		stop_c();
	endtask
	// Master acknowledges every byte but the last
	task automatic rd(input logic [7:0] a, input int n, output logic [7:0] q0, q1);
		logic k;
		start_c();
		xfer({TARGET_ADDRESS, 1'b0}, 1'b1, q0, k);
		xfer(a, 1'b1, q0, k);
		start_c();
		xfer({TARGET_ADDRESS, 1'b1}, 1'b1, q0, k);
		xfer(8'hFF, n == 1, q0, k);
		if (n > 1)
			xfer(8'hFF, 1'b1, q1, k);
		stop_c();
	endtask
endmodule

// *** tb/tb.sv ***
/*
 * Self-checking bench of the backlight register bank.
 * Assumes the serial host model and the bound port checker.
 */
`timescale 1ns/100ps
module tb;
	import backlight_pkg::*;
	localparam logic [7:0] ID = 8'h3C; // Arbitrary identification value
	logic clk, srst, pwm_in, en_pin, nvm_ready, scl, host_sda, ack;
	logic sda_out, sda_oe_n, led_pwm, chip_on, backlight_on, fault_n;
	logic [7:0] brightness_level_out, q0, q1;
	logic [5:0] direct_outputs;
	logic [10:0] temp_value;
	logic [2:0] nvm_seen = 3'h0;
	fault_bits_t fault_events;
	nvm_cmd_t nvm_cmd;
	int num_errors = 0;
	int tests_run = 0;
	int cycles = 0;
	wire sda_line = host_sda & (sda_oe_n | sda_out);
	backlight_control_registers #(.TICK_DIV(1), .IDENT_VALUE(ID)) dut (
		.clk(clk), .srst(srst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
		.sda_oe_n(sda_oe_n), .pwm_in(pwm_in), .en_pin(en_pin), .fault_events(fault_events),
		.temp_value(temp_value), .nvm_ready(nvm_ready), .nvm_cmd(nvm_cmd), .led_pwm(led_pwm),
		.chip_on(chip_on), .backlight_on(backlight_on), .direct_outputs(direct_outputs),
		.brightness_level_out(brightness_level_out), .fault_n(fault_n));
	serial_host host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_o(host_sda));
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Command pulses last one cycle, so gather them; also the hang limit
	always @(posedge clk)
	begin
		// Pulses before reset are unknown and would poison the gather
		if (!srst)
		begin
			nvm_seen <= nvm_seen | nvm_cmd;
		end
		cycles <= cycles + 1;
		if (cycles == 60000)
		begin
			num_errors++;
			final_report();
		end
	end
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
		host.rd(a, 1, q0, q1);
		chk(q0, exp);
	endtask
	task automatic final_report;
		$display("errors %0d, comparisons %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic t_reset;
		chk(brightness_level_out, 8'h00);
		chk({7'h0, fault_n}, 8'h01);
		rreg(ADDR_BRIGHTNESS, RESET_BRIGHTNESS);
		rreg(ADDR_DEVICE_CTRL, 8'h00);
		rreg(ADDR_FAULT, RESET_FAULT);
		rreg(ADDR_IDENT, ID);
		rreg(ADDR_TEMP_HIGH, 8'hB4);
		rreg(ADDR_TEMP_LOW, 8'h60);
		rreg(8'h10, 8'h00);
	endtask
	task automatic t_addr;
		host.probe(8'h5A, ack);
		chk({7'h0, ack}, 8'h00);
		host.probe({TARGET_ADDRESS, 1'b0}, ack);
		chk({7'h0, ack}, 8'h01);
	endtask
	// Burst write and read, then duty over one full counter period
	task automatic t_burst;
		int n;
		host.wr(ADDR_BRIGHTNESS, 8'h80, 8'h05, 2);
		host.rd(ADDR_BRIGHTNESS, 2, q0, q1);
		chk(q0, 8'h80);
		chk(q1, 8'h05);
		chk(brightness_level_out, 8'h80);
		chk({6'h0, chip_on, backlight_on}, 8'h03);
		n = 0;
		repeat (256)
		begin
			@(posedge clk);
			n += led_pwm;
		end
		chk(8'(n), 8'h80);
		host.wr(ADDR_DEVICE_CTRL, 8'h04, 8'h00, 1);
		chk({6'h0, chip_on, backlight_on}, 8'h00);
	endtask
	task automatic t_bits;
		host.wr(ADDR_DEVICE_CTRL, 8'hF8, 8'h00, 1);
		rreg(ADDR_DEVICE_CTRL, 8'h00);
		host.wr(ADDR_DIRECT, 8'hFF, 8'h00, 1);
		rreg(ADDR_DIRECT, 8'h7E);
		chk({2'h0, direct_outputs}, 8'h3F);
		host.wr(ADDR_IDENT, 8'h00, 8'h00, 1);
		rreg(ADDR_IDENT, ID);
		host.wr(ADDR_NVM, 8'h02, 8'h00, 1);
		chk({5'h0, nvm_seen}, 8'h02);
		host.wr(ADDR_NVM, 8'h07, 8'h00, 1);
		rreg(ADDR_NVM, 8'h80);
		chk({5'h0, nvm_seen}, 8'h07);
	endtask
	// Pin modes, 00 with the enable bit clear and 01 with it set, then pass-through
	task automatic t_modes;
		for (int m = 0; m < 2; m++)
		begin
			host.wr(ADDR_DEVICE_CTRL, {5'h0, m[1:0], m[0]}, 8'h00, 1);
			pwm_in <= 1'b1;
			wt(600);
			chk(brightness_level_out, 8'hFF);
			chk({7'h0, chip_on}, 8'h01);
			pwm_in <= 1'b0;
			wt(600);
			chk({7'h0, chip_on}, 8'h00);
		end
		host.wr(ADDR_DEVICE_CTRL, 8'h06, 8'h00, 1);
		pwm_in <= 1'b1;
		wt(3);
		chk({7'h0, led_pwm}, 8'h01);
		pwm_in <= 1'b0;
		wt(3);
		chk({7'h0, led_pwm}, 8'h00);
	endtask
	task automatic t_fault;
		for (int i = 0; i < 8; i++)
		begin
			fault_events <= 8'h01 << i;
			wt(1);
			fault_events <= 8'h00;
			wt(3);
			chk({7'h0, fault_n}, 8'h00);
			rreg(ADDR_FAULT, 8'h01 << i);
			rreg(ADDR_FAULT, 8'h00);
		end
		fault_events <= 8'h80;
		wt(1);
		fault_events <= 8'h00;
		en_pin <= 1'b0;
		wt(2);
		en_pin <= 1'b1;
		wt(2);
		chk({7'h0, fault_n}, 8'h01);
		rreg(ADDR_FAULT, 8'h00);
	endtask
	initial
	begin
		srst = 1'b1;
		pwm_in = 1'b0;
		en_pin = 1'b1;
		nvm_ready = 1'b1;
		temp_value = 11'h5A3;
		fault_events = 8'h00;
		wt(3);
		srst <= 1'b0;
		wt(1);
		t_reset();
		t_addr();
		t_burst();
		t_bits();
		t_modes();
		t_fault();
		final_report();
	end
endmodule
